// *** core/vmp_status_regs.sv ***
// Bus threshold match, change, power and debug event registers behind an AXI4-Lite slave.
`timescale 1ns/100ps
`include "vmp_params.svh"
// Functional notes
// - Match bits 5:2 and 0, others reserved
// - Match bit set while above threshold
// - Match reads zero until comparator enabled, unless standalone
// - Per-bit debounce when clear-enable set
// - Change flag set on any match change
// - Write one clears change flag
// - Power bit 7 set once, first match
// - Bit 6 cable discharge error, standalone source
// - Bits 5,1 back-drive level flags
// - Bit 4 bus discharge timeout pulse
// - Bits 3,2 cable FET power levels
// - Bit 0 cable over-current level
// - Debug bit 3 cable discharging, standalone source
// - Debug bit 2 bus discharging level
// - Debug bits 1,0 config sampling done
// - Change flags gated by match enable
// - Power, debug flags gated by enables
module vmp_status_regs
   import vmp_pkg::*;
#(
   parameter int DEB_CYCLES = `VMP_DEB_CYCLES,
   parameter int ADDR_W = `VMP_ADDR_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [7:0] bus_sense_hits,
   input wire vmp_evt_t events,
   output logic irq
);

   // ------------------------------------------------------------
   // Parameter checks and helpers
   // ------------------------------------------------------------
   localparam logic [7:0] DEB_LAST = 8'(DEB_CYCLES - 1);

   if (DEB_CYCLES < 1 || DEB_CYCLES > 256) begin : g_deb_check
      $error("DEB_CYCLES must lie in 1..256");
   end
   if (ADDR_W < 14 || ADDR_W > 32) begin : g_addr_check
      $error("ADDR_W must lie in 14..32");
   end

   function automatic logic [11:0] reg_index(input logic [ADDR_W-1:0] addr);
      reg_index = addr[13:2];
   endfunction : reg_index

   function automatic logic is_mapped(input logic [11:0] idx);
      case (idx)
         `VMP_IDX_MATCH, `VMP_IDX_CHANGE, `VMP_IDX_POWER, `VMP_IDX_DEBUG,
         `VMP_IDX_MATCH_EN, `VMP_IDX_POWER_EN, `VMP_IDX_DEBUG_EN,
         `VMP_IDX_CTRL, `VMP_IDX_DBCLR: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction : is_mapped

   // Set wins over clear so an event in the clearing cycle is kept.
   function automatic logic [7:0] w1c(input logic [7:0] old, input logic [7:0] clr,
                                      input logic [7:0] set);
      w1c = (old & ~clr) | set;
   endfunction : w1c

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
   logic awh_reg, awh_next, wh_reg, wh_next, wlane_reg, wlane_next, seen_reg, seen_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [7:0] wbyte_reg, wbyte_next, sync1_reg, sync1_next, sync2_reg, sync2_next;
   logic [7:0] match_reg, match_next, change_reg, change_next, power_reg, power_next;
   logic [7:0] debug_reg, debug_next, match_en_reg, match_en_next, dbclr_reg, dbclr_next;
   logic [7:0] power_en_reg, power_en_next, debug_en_reg, debug_en_next;
   logic [7:0] cnt_reg [8], cnt_next [8];
   vmp_ctrl_t ctrl_reg, ctrl_next;

   logic wr_fire, wr_en, dfp_mode, cmp_gate, first_pulse;
   logic [11:0] wr_idx, rd_idx;
   logic [7:0] pwr_set, dbg_set;

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   assign awready = !awh_reg && !bvalid_reg;
   assign wready = !wh_reg && !bvalid_reg;
   assign arready = !rvalid_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

   assign wr_fire = awh_reg && wh_reg;
   assign wr_idx = reg_index(awaddr_reg);
   assign rd_idx = reg_index(araddr);
   // Only byte lane 0 holds register bits; a write without it changes nothing.
   assign wr_en = wr_fire && wlane_reg && is_mapped(wr_idx);

   always_comb begin : bus_next
      awh_next = awh_reg;
      awaddr_next = awaddr_reg;
      wh_next = wh_reg;
      wbyte_next = wbyte_reg;
      wlane_next = wlane_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (awvalid && awready) begin
         awh_next = 1'b1;
         awaddr_next = awaddr;
      end
      if (wvalid && wready) begin
         wh_next = 1'b1;
         wbyte_next = wdata[7:0];
         wlane_next = wstrb[0];
      end
      if (bvalid_reg && bready) begin
         bvalid_next = 1'b0;
      end
      if (wr_fire) begin
         awh_next = 1'b0;
         wh_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = is_mapped(wr_idx) ? `VMP_RESP_OKAY : `VMP_RESP_SLVERR;
      end
      if (rvalid_reg && rready) begin
         rvalid_next = 1'b0;
      end
      if (arvalid && arready) begin
         rvalid_next = 1'b1;
         rresp_next = is_mapped(rd_idx) ? `VMP_RESP_OKAY : `VMP_RESP_SLVERR;
         rdata_next = 32'h0000_0000;
         case (rd_idx)
            `VMP_IDX_MATCH: rdata_next[7:0] = match_reg;
            `VMP_IDX_CHANGE: rdata_next[7:0] = change_reg;
            `VMP_IDX_POWER: rdata_next[7:0] =
               power_reg & (dfp_mode ? 8'hff : `VMP_POWER_MASK_NODFP);
            `VMP_IDX_DEBUG: rdata_next[7:0] =
               debug_reg & (dfp_mode ? `VMP_DEBUG_MASK : `VMP_DEBUG_MASK_NODFP);
            `VMP_IDX_MATCH_EN: rdata_next[7:0] = match_en_reg;
            `VMP_IDX_POWER_EN: rdata_next[7:0] = power_en_reg;
            `VMP_IDX_DEBUG_EN: rdata_next[7:0] = debug_en_reg;
            `VMP_IDX_CTRL: rdata_next[7:0] = {3'h0, ctrl_reg};
            `VMP_IDX_DBCLR: rdata_next[7:0] = dbclr_reg;
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge aclk) begin : bus_regs
      if (!aresetn) begin
         awh_reg <= 1'b0;
         awaddr_reg <= '0;
         wh_reg <= 1'b0;
         wbyte_reg <= `VMP_RST_BYTE;
         wlane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `VMP_RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `VMP_RESP_OKAY;
      end else begin
         awh_reg <= awh_next;
         awaddr_reg <= awaddr_next;
         wh_reg <= wh_next;
         wbyte_reg <= wbyte_next;
         wlane_reg <= wlane_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   // ------------------------------------------------------------
   // Threshold match synchroniser and debouncer
   // ------------------------------------------------------------
   assign dfp_mode = ctrl_reg.standalone && ctrl_reg.source_facing_role;
   assign cmp_gate = !ctrl_reg.standalone && !ctrl_reg.cmp_enable;

   always_comb begin : match_next_calc
      sync1_next = bus_sense_hits;
      sync2_next = sync1_reg;
      match_next = match_reg;
      for (int i = 0; i < 8; i++) begin
         cnt_next[i] = 8'h00;
         if (!dbclr_reg[i]) begin
            match_next[i] = sync2_reg[i];
         end else if (sync2_reg[i] != match_reg[i]) begin
            // A bit moves only after it has disagreed for DEB_CYCLES cycles.
            if (cnt_reg[i] == DEB_LAST) begin
               match_next[i] = sync2_reg[i];
            end else begin
               cnt_next[i] = cnt_reg[i] + 8'h01;
            end
         end
      end
      match_next = match_next & `VMP_MATCH_MASK;
      if (cmp_gate) begin
         match_next = 8'h00;
      end
   end

   always_ff @(posedge aclk) begin : match_regs
      if (!aresetn) begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
         match_reg <= 8'h00;
         for (int i = 0; i < 8; i++) begin
            cnt_reg[i] <= 8'h00;
         end
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         match_reg <= match_next;
         for (int i = 0; i < 8; i++) begin
            cnt_reg[i] <= cmp_gate ? 8'h00 : cnt_next[i];
         end
      end
   end

   // ------------------------------------------------------------
   // Event flags, enables and control
   // ------------------------------------------------------------
   // The first match counts as valid once no debounced bit still disagrees.
   assign first_pulse = ctrl_reg.cmp_enable && !seen_reg &&
                        (((sync2_reg ^ match_reg) & dbclr_reg & `VMP_MATCH_MASK) == 8'h00);

   always_comb begin : event_sets
      pwr_set = 8'h00;
      pwr_set[`VMP_PWR_FIRST_VALID] = first_pulse;
      pwr_set[`VMP_PWR_CABLE_DISCH_ERR] = dfp_mode && !ctrl_reg.cable_disch_ctrl[1] &&
         events.cable_discharge_expired && events.cable_above_threshold;
      pwr_set[5] = events.cc2_back_drive;
      pwr_set[4] = events.bus_discharge_timeout;
      pwr_set[3] = events.cable2_fet_on;
      pwr_set[2] = events.cable1_fet_on;
      pwr_set[1] = events.cc1_back_drive;
      pwr_set[`VMP_PWR_OVER_CURRENT] = events.cable_over_current;
      dbg_set = 8'h00;
      dbg_set[`VMP_DBG_CABLE_DISCH] = dfp_mode && events.cable_supply_discharging;
      dbg_set[2] = events.bus_supply_discharging;
      dbg_set[1:0] = events.config_select_done;
   end

   always_comb begin : flag_next_calc
      logic [7:0] clr_chg, clr_pwr, clr_dbg;
      clr_chg = (wr_en && wr_idx == `VMP_IDX_CHANGE) ? wbyte_reg : 8'h00;
      clr_pwr = (wr_en && wr_idx == `VMP_IDX_POWER) ? wbyte_reg : 8'h00;
      clr_dbg = (wr_en && wr_idx == `VMP_IDX_DEBUG) ? wbyte_reg : 8'h00;
      change_next = w1c(change_reg, clr_chg, match_reg ^ match_next);
      // Level sources set again each cycle; pulse sources only on a new pulse.
      power_next = w1c(power_reg, clr_pwr, pwr_set);
      debug_next = w1c(debug_reg, clr_dbg, dbg_set) & `VMP_DEBUG_MASK;
      seen_next = seen_reg || first_pulse;
      match_en_next = match_en_reg;
      power_en_next = power_en_reg;
      debug_en_next = debug_en_reg;
      ctrl_next = ctrl_reg;
      dbclr_next = dbclr_reg;
      if (wr_en) begin
         case (wr_idx)
            `VMP_IDX_MATCH_EN: match_en_next = wbyte_reg & `VMP_MATCH_MASK;
            `VMP_IDX_POWER_EN: power_en_next = wbyte_reg;
            `VMP_IDX_DEBUG_EN: debug_en_next = wbyte_reg & `VMP_DEBUG_MASK;
            `VMP_IDX_CTRL: ctrl_next = vmp_ctrl_t'(wbyte_reg[4:0]);
            `VMP_IDX_DBCLR: dbclr_next = wbyte_reg & `VMP_MATCH_MASK;
            default: ctrl_next = ctrl_reg;
         endcase
      end
   end

   always_ff @(posedge aclk) begin : flag_regs
      if (!aresetn) begin
         change_reg <= 8'h00;
         power_reg <= 8'h00;
         debug_reg <= 8'h00;
         seen_reg <= 1'b0;
         match_en_reg <= 8'h00;
         power_en_reg <= 8'h00;
         debug_en_reg <= 8'h00;
         ctrl_reg <= '0;
         dbclr_reg <= 8'h00;
      end else begin
         change_reg <= change_next;
         power_reg <= power_next;
         debug_reg <= debug_next;
         seen_reg <= seen_next;
         match_en_reg <= match_en_next;
         power_en_reg <= power_en_next;
         debug_en_reg <= debug_en_next;
         ctrl_reg <= ctrl_next;
         dbclr_reg <= dbclr_next;
      end
   end

   // Bit 6 and debug bit 3 are hidden outside standalone source role, so they cannot interrupt.
   assign irq = (|(change_reg & match_en_reg)) ||
                (|(power_reg & power_en_reg & (dfp_mode ? 8'hff : `VMP_POWER_MASK_NODFP))) ||
                (|(debug_reg & debug_en_reg &
                   (dfp_mode ? `VMP_DEBUG_MASK : `VMP_DEBUG_MASK_NODFP)));

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_ar_take;
      arvalid && arready;
   endsequence

   sequence s_both_held;
      awh_reg && wh_reg;
   endsequence

   a_read_answer: assert property (s_ar_take |=> rvalid && !arready)
      else $error("read answer late");
   a_write_answer: assert property (s_both_held |=> bvalid && !awh_reg && !wh_reg)
      else $error("write answer missing");
   a_match_reserved: assert property ((match_reg & ~`VMP_MATCH_MASK) == 8'h00)
      else $error("reserved match bit set");
   a_match_gated: assert property (cmp_gate |=> match_reg == 8'h00)
      else $error("match visible before comparator enable");
   a_change_follows: assert property (
      (match_reg != $past(match_reg)) |-> ((change_reg & (match_reg ^ $past(match_reg))) ==
                                           (match_reg ^ $past(match_reg))))
      else $error("match change not flagged");
   a_w1c_clear: assert property (
      (wr_en && wr_idx == `VMP_IDX_CHANGE && match_next == match_reg) |=>
      (change_reg & $past(wbyte_reg)) == 8'h00)
      else $error("change flag not cleared");
   a_first_once: assert property ($rose(power_reg[`VMP_PWR_FIRST_VALID]) |->
                                  $past(first_pulse) && seen_reg)
      else $error("first match flag without first event");
   a_level_reset: assert property (events.cable_over_current |=> power_reg[0])
      else $error("level flag not re-set");
   a_cfg_done: assert property (events.config_select_done[0] |=> ##[0:1] debug_reg[0])
      else $error("sampling done not flagged");
   a_irq_quiet: assert property (
      (change_reg == 8'h00 && power_reg == 8'h00 && debug_reg == 8'h00) |-> !irq)
      else $error("interrupt without status");
endmodule : vmp_status_regs

// *** dv/vmp_status_regs_tb.sv ***
// Self-checking bench of the bus threshold match, change, power and debug event registers.
`timescale 1ns/100ps
`include "vmp_params.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
   $display("[ERR] t=%0t got %h exp %h", $time, got, exp); end end

module vmp_status_regs_tb;
   import vmp_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [13:0] awaddr = 14'h0;
   logic [13:0] araddr = 14'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [3:0] wstrb = 4'h0;
   logic [1:0] bresp, rresp, resp;
   logic [7:0] hits = 8'h00;
   logic [7:0] m_match, m_prev;
   logic [31:0] rd_word;
   vmp_evt_t ev = '0;
   int err_total = 0;
   int check_count = 0;

   always #20 aclk = ~aclk;

   vmp_status_regs #(.DEB_CYCLES(2), .ADDR_W(14)) dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .bus_sense_hits(hits), .events(ev), .irq(irq)
   );

   // ------------------------------------------------------------
   // Bus tasks
   // ------------------------------------------------------------
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   task automatic give_up;
      err_total++;
      end_sim();
   endtask : give_up

   task automatic wr(input logic [11:0] i, input logic [7:0] d, output logic [1:0] r);
      int n;
      bit aw_ok, w_ok, aw_now, w_now, b_now;
      aw_ok = 0;
      w_ok = 0;
      b_now = 0;
      @(posedge aclk);
      awaddr <= {i, 2'b00};
      wdata <= {24'h0, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Ready and valid are looked at mid-cycle, where they are settled, so the
      // bench knows what the coming edge takes without racing the slave's flops.
      for (n = 0; !(aw_ok && w_ok); n++) begin
         if (n > 50) give_up();
         @(negedge aclk);
         aw_now = (awready === 1'b1);
         w_now = (wready === 1'b1);
         @(posedge aclk);
         if (!aw_ok && aw_now) begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (!w_ok && w_now) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
      end
      for (n = 0; n < 60 && !b_now; n++) begin
         @(negedge aclk);
         b_now = (bvalid === 1'b1);
         r = bresp;
         @(posedge aclk);
      end
      if (!b_now) give_up();
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] i, output logic [31:0] d, output logic [1:0] r);
      int n;
      bit ar_now, r_now;
      r_now = 0;
      @(posedge aclk);
      araddr <= {i, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 60 && !r_now; n++) begin
         @(negedge aclk);
         ar_now = (arvalid === 1'b1 && arready === 1'b1);
         r_now = (rvalid === 1'b1);
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ar_now) arvalid <= 1'b0;
      end
      if (!r_now) give_up();
      rready <= 1'b0;
   endtask : rd

   task automatic rc(input logic [11:0] i, input logic [7:0] e);
      rd(i, rd_word, resp);
      `CHK(rd_word, {24'h0, e})
      `CHK(resp, `VMP_RESP_OKAY)
   endtask : rc

   task automatic wc(input logic [11:0] i, input logic [7:0] d);
      wr(i, d, resp);
      `CHK(resp, `VMP_RESP_OKAY)
   endtask : wc

   // The interrupt is combinational from flops, so it is compared mid-cycle.
   task automatic irq_chk(input logic e);
      @(negedge aclk);
      `CHK(irq, e)
      @(posedge aclk);
   endtask : irq_chk

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'h642568d5));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rc(`VMP_IDX_MATCH, 8'h00);
      rc(`VMP_IDX_CHANGE, 8'h00);
      rc(`VMP_IDX_POWER, 8'h00);
      rc(`VMP_IDX_DEBUG, 8'h00);
      rd(12'h900, rd_word, resp);
      `CHK(resp, `VMP_RESP_SLVERR)
      wr(12'h901, 8'hff, resp);
      `CHK(resp, `VMP_RESP_SLVERR)
      // Comparator still off: the threshold levels must not show.
      hits <= 8'($urandom) | 8'h04;
      repeat (8) @(posedge aclk);
      rc(`VMP_IDX_MATCH, 8'h00);
      rc(`VMP_IDX_CHANGE, 8'h00);
      wc(`VMP_IDX_CTRL, 8'h01);
      repeat (8) @(posedge aclk);
      m_match = hits & `VMP_MATCH_MASK;
      rc(`VMP_IDX_MATCH, m_match);
      rc(`VMP_IDX_CHANGE, m_match);
      rc(`VMP_IDX_POWER, 8'h80);
      wc(`VMP_IDX_CHANGE, 8'h00);
      rc(`VMP_IDX_CHANGE, m_match);
      wc(`VMP_IDX_CHANGE, 8'hff);
      rc(`VMP_IDX_CHANGE, 8'h00);
      wc(`VMP_IDX_POWER, 8'h80);
      repeat (6) @(posedge aclk);
      rc(`VMP_IDX_POWER, 8'h00);
      // Debounced bits follow only after the input settles.
      wc(`VMP_IDX_DBCLR, 8'h3d);
      m_prev = m_match;
      hits <= hits ^ 8'h3d;
      repeat (12) @(posedge aclk);
      m_match = hits & `VMP_MATCH_MASK;
      rc(`VMP_IDX_MATCH, m_match);
      rc(`VMP_IDX_CHANGE, m_match ^ m_prev);
      wc(`VMP_IDX_CHANGE, 8'hff);
      hits <= hits ^ 8'h04;
      repeat (12) @(posedge aclk);
      rc(`VMP_IDX_CHANGE, 8'h04);
      irq_chk(1'b0);
      wc(`VMP_IDX_MATCH_EN, 8'h04);
      irq_chk(1'b1);
      wc(`VMP_IDX_CHANGE, 8'h04);
      irq_chk(1'b0);
      // Level sources re-set after a clear; a pulse source does not.
      ev.cc2_back_drive <= 1'b1;
      ev.cc1_back_drive <= 1'b1;
      ev.cable2_fet_on <= 1'b1;
      ev.cable1_fet_on <= 1'b1;
      ev.cable_over_current <= 1'b1;
      ev.bus_discharge_timeout <= 1'b1;
      @(posedge aclk);
      ev.bus_discharge_timeout <= 1'b0;
      rc(`VMP_IDX_POWER, 8'h3f);
      wc(`VMP_IDX_POWER, 8'hff);
      rc(`VMP_IDX_POWER, 8'h2f);
      irq_chk(1'b0);
      wc(`VMP_IDX_POWER_EN, 8'h01);
      irq_chk(1'b1);
      ev.cc2_back_drive <= 1'b0;
      ev.cc1_back_drive <= 1'b0;
      ev.cable2_fet_on <= 1'b0;
      ev.cable1_fet_on <= 1'b0;
      ev.cable_over_current <= 1'b0;
      wc(`VMP_IDX_POWER, 8'hff);
      rc(`VMP_IDX_POWER, 8'h00);
      // Debug flags; bit 3 needs standalone source-facing operation.
      ev.bus_supply_discharging <= 1'b1;
      ev.cable_supply_discharging <= 1'b1;
      ev.config_select_done <= 2'b11;
      @(posedge aclk);
      ev.config_select_done <= 2'b00;
      rc(`VMP_IDX_DEBUG, 8'h07);
      wc(`VMP_IDX_DEBUG, 8'hff);
      rc(`VMP_IDX_DEBUG, 8'h04);
      wc(`VMP_IDX_CTRL, 8'h07);
      wc(`VMP_IDX_DEBUG, 8'hff);
      rc(`VMP_IDX_DEBUG, 8'h0c);
      wc(`VMP_IDX_DEBUG_EN, 8'h08);
      irq_chk(1'b1);
      ev.cable_above_threshold <= 1'b1;
      ev.cable_discharge_expired <= 1'b1;
      @(posedge aclk);
      ev.cable_discharge_expired <= 1'b0;
      rc(`VMP_IDX_POWER, 8'h40);
      wc(`VMP_IDX_POWER, 8'hff);
      wc(`VMP_IDX_CTRL, 8'h17);
      ev.cable_discharge_expired <= 1'b1;
      @(posedge aclk);
      ev.cable_discharge_expired <= 1'b0;
      rc(`VMP_IDX_POWER, 8'h00);
      end_sim();
   end
endmodule : vmp_status_regs_tb

// *** shared/vmp_params.svh ***
// Register indices, field positions, reset values and counts of the bus-match status block.
`ifndef VMP_PARAMS_SVH
`define VMP_PARAMS_SVH
`define VMP_IDX_MATCH 12'h808
`define VMP_IDX_CHANGE 12'h809
`define VMP_IDX_POWER 12'h80a
`define VMP_IDX_DEBUG 12'h80b
`define VMP_IDX_MATCH_EN 12'h814
`define VMP_IDX_POWER_EN 12'h815
`define VMP_IDX_DEBUG_EN 12'h816
`define VMP_IDX_CTRL 12'h820
`define VMP_IDX_DBCLR 12'h821
`define VMP_MATCH_MASK 8'h3d
`define VMP_DEBUG_MASK 8'h0f
`define VMP_DEBUG_MASK_NODFP 8'h07
`define VMP_POWER_MASK_NODFP 8'hbf
`define VMP_CTRL_MASK 8'h1f
`define VMP_RST_BYTE 8'h00
`define VMP_PWR_FIRST_VALID 7
`define VMP_PWR_CABLE_DISCH_ERR 6
`define VMP_PWR_OVER_CURRENT 0
`define VMP_DBG_CABLE_DISCH 3
`define VMP_RESP_OKAY 2'h0
`define VMP_RESP_SLVERR 2'h2
`define VMP_DEB_CYCLES 2
`define VMP_ADDR_W 14
`endif

// *** shared/vmp_pkg.sv ***
// Types shared by the bus-match status block.
package vmp_pkg;
   typedef struct packed {
      logic cc2_back_drive;
      logic bus_discharge_timeout;
      logic cable2_fet_on;
      logic cable1_fet_on;
      logic cc1_back_drive;
      logic cable_over_current;
      logic cable_discharge_expired;
      logic cable_above_threshold;
      logic cable_supply_discharging;
      logic bus_supply_discharging;
      logic [1:0] config_select_done;
   } vmp_evt_t;
   typedef struct packed {
      logic [1:0] cable_disch_ctrl;
      logic source_facing_role;
      logic standalone;
      logic cmp_enable;
   } vmp_ctrl_t;
endpackage : vmp_pkg
